// file: dv/sec_link_props.sv
// Concurrent checks on the link between controller and submodule
`timescale 1ns/1ps
module sec_link_props (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic cyc_req,
	input wire logic [47:0] out_image,
	input wire logic in_valid,
	input wire logic [79:0] in_image,
	input wire logic rec_req,
	input wire logic [15:0] rec_index,
	input wire logic rec_ack,
	input wire logic rec_ok
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	// ----------------------------------------
	// Cyclic answers
	// ----------------------------------------
	a_answer_next: assert property (cyc_req |=> in_valid)
		else $error("no answer one clock after cycle request");
	a_answer_has_cause: assert property (in_valid |-> $past(cyc_req))
		else $error("answer without cycle request");
	a_reserved_zero: assert property (in_valid |-> in_image[79:74] == 6'h00
		&& !in_image[70] && !in_image[65])
		else $error("reserved status bit set");
	a_safe_no_ack: assert property (in_valid && in_image[72] |-> !in_image[68])
		else $error("safe flag set while awaiting acknowledgment");
	// Relies on the fixed ten clock cycle period of the controller
	a_safe_drops_prep: assert property (cyc_req && out_image[33:32] == 2'h1
		|-> ##11 (in_valid && !in_image[68]))
		else $error("safe flag not cleared by preparation");
	a_ok_err_apart: assert property (in_valid && in_image[66] |-> !in_image[67])
		else $error("preset success and error together");
	a_active_alone: assert property (in_valid && in_image[69] |-> !in_image[67])
		else $error("preset active with preset error");

	// ----------------------------------------
	// Parameter record
	// ----------------------------------------
	a_rec_ack_next: assert property (rec_req |=> rec_ack)
		else $error("record not acknowledged next clock");
	a_rec_ack_cause: assert property (rec_ack |-> $past(rec_req))
		else $error("record acknowledge without request");
	a_rec_index_one: assert property (rec_req |-> rec_index == 16'h0001)
		else $error("record sent to wrong index");
	a_rec_ok_hold: assert property (!rec_ack |-> $stable(rec_ok))
		else $error("record result changed without acknowledge");
endmodule : sec_link_props

// file: dv/tb_safe_encoder_cyclic_data.sv
// Self-checking bench for the controller and submodule pair
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_safe_encoder_cyclic_data;
	localparam logic [31:0] RNG = 32'h00001000;
	logic i_clk = 1'h0;
	logic i_rst = 1'h1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic irq;
	logic [31:0] raw_pos = 32'h123;
	logic [31:0] vel = 32'hFFFFFF85;
	logic vel_oor = 1'h0;
	logic fault = 1'h0;
	logic other_busy = 1'h0;
	logic [31:0] dev_pos;
	logic busy;
	logic params_ok;
	logic [31:0] meas_range;
	logic ack_req;
	logic pload;
	logic [31:0] pval;
	logic [2:0] vfmt;
	logic dirn;
	logic [31:0] rd;
	logic [31:0] pos_exp = 32'h123;
	int n_errors = 0;
	int samples_checked = 0;
	int busy_cnt = 0;
	int load_cnt = 0;
	int cyc_cnt = 0;

	sec_link_if lnk ();
	sec_host i_sec_host (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'h1), .i_hsel(1'h1),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(), .o_irq(irq), .link(lnk));
	sec_device i_sec_device (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'h1), .link(lnk),
		.i_raw_pos(raw_pos), .i_velocity(vel), .i_vel_out_of_range(vel_oor),
		.i_safe_fault(fault), .i_other_preset_busy(other_busy), .o_position(dev_pos),
		.o_preset_load(pload), .o_preset_value(pval), .o_preset_busy(busy),
		.o_params_ok(params_ok), .o_meas_range(meas_range), .o_vel_format(vfmt),
		.o_direction(dirn), .o_ack_req(ack_req));
	sec_link_props i_sec_link_props (.i_clk(i_clk), .i_rst(i_rst), .cyc_req(lnk.cyc_req),
		.out_image(lnk.out_image), .in_valid(lnk.in_valid), .in_image(lnk.in_image),
		.rec_req(lnk.rec_req), .rec_index(lnk.rec_index), .rec_ack(lnk.rec_ack),
		.rec_ok(lnk.rec_ok));

	// ----------------------------------------
	// Clock, busy counter and hang guard
	// ----------------------------------------
	always #50 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc_cnt++;
		if (busy === 1'h1)
			busy_cnt++;
		if (pload === 1'h1)
			load_cnt++;
		if (cyc_cnt == 20000) begin
			n_errors++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Bus and helper tasks
	// ----------------------------------------
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge i_clk);
		while (hready !== 1'h1) @(posedge i_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge i_clk);
		while (hready !== 1'h1) @(posedge i_clk);
		rd = hrdata;
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(a, 1'h1, d);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		ahb(a, 1'h0, 32'h0);
		`CHK($sformatf("reg %0h", a), e & m, rd & m)
	endtask : rchk
	// Two and a half link periods, so the next image surely reflects the change
	task automatic idle();
		repeat (25) @(posedge i_clk);
	endtask : idle
	function automatic logic [31:0] crc48(input logic [47:0] d);
		logic [31:0] c;
		c = sec_pkg::CRC_INIT;
		for (int k = 47; k >= 0; k--)
			c = (c << 1) ^ ((c[31] ^ d[k]) ? sec_pkg::CRC_POLY : 32'h0);
		return c;
	endfunction : crc48

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_records();
		rchk(sec_pkg::REG_PAR_RANGE, 32'hFFFFFFFF, 32'h20000000);
		rchk(8'h40, 32'hFFFFFFFF, 32'h0);
		wr(sec_pkg::REG_CTRL, 32'h8);
		wr(sec_pkg::REG_PAR_RANGE, RNG);
		wr(sec_pkg::REG_PAR_CFG, 32'h0002);
		wr(sec_pkg::REG_PAR_CRC, ~crc48({8'h00, RNG, 8'h02}));
		wr(sec_pkg::REG_PAR_GO, 32'h1);
		idle();
		rchk(sec_pkg::REG_PAR_GO, 32'h3, 32'h1);
		`CHK("params ok", 1'h0, params_ok)
		`CHK("format kept", 3'h1, vfmt)
		wr(sec_pkg::REG_PAR_CRC, crc48({8'h00, RNG, 8'h02}));
		wr(sec_pkg::REG_PAR_GO, 32'h1);
		idle();
		rchk(sec_pkg::REG_PAR_GO, 32'h3, 32'h3);
		`CHK("range", RNG, meas_range)
		`CHK("velocity format", 3'h2, vfmt)
		`CHK("direction", 1'h0, dirn)
		wr(sec_pkg::REG_IRQ_EN, 32'hC);
	endtask : t_records

	task automatic t_cycle();
		vel_oor <= 1'h1;
		idle();
		rchk(sec_pkg::REG_POS, 32'hFFFFFFFF, 32'h123);
		rchk(sec_pkg::REG_VEL, 32'hFFFFFFFF, 32'hFFFFFF85);
		rchk(sec_pkg::REG_STATUS, 32'hFFFF, 32'h0011);
		`CHK("wire position", 32'h123, lnk.in_image[63:32])
		`CHK("wire velocity", 32'hFFFFFF85, lnk.in_image[31:0])
		vel_oor <= 1'h0;
		wr(sec_pkg::REG_PRESET, 32'h77);
		wr(sec_pkg::REG_CTRL, 32'hA);
		idle();
		rchk(sec_pkg::REG_POS, 32'hFFFFFFFF, 32'h123);
		rchk(sec_pkg::REG_STATUS, 32'h3D, 32'h10);
		wr(sec_pkg::REG_CTRL, 32'h8);
		idle();
	endtask : t_cycle

	task automatic do_preset(input logic [31:0] v, input logic [31:0] st);
		int b0;
		int l0;
		logic [31:0] p0;
		b0 = busy_cnt;
		l0 = load_cnt;
		p0 = pval;
		wr(sec_pkg::REG_PRESET, v);
		wr(sec_pkg::REG_CTRL, 32'h9);
		idle();
		rchk(sec_pkg::REG_STATUS, 32'h10, 32'h0);
		wr(sec_pkg::REG_CTRL, 32'hB);
		idle();
		pos_exp = st[2] ? v : pos_exp;
		rchk(sec_pkg::REG_POS, 32'hFFFFFFFF, pos_exp);
		rchk(sec_pkg::REG_STATUS, 32'h2C, st);
		`CHK("busy clocks", b0 + int'(st[2]), busy_cnt)
		`CHK("load pulses", l0 + int'(st[2]), load_cnt)
		`CHK("preset value", st[2] ? v : p0, pval)
		`CHK("position", pos_exp, dev_pos)
		wr(sec_pkg::REG_CTRL, 32'h8);
		idle();
		rchk(sec_pkg::REG_STATUS, 32'h1C, 32'h10);
	endtask : do_preset

	task automatic t_irq();
		`CHK("irq raised", 1'h1, irq)
		rchk(sec_pkg::REG_IRQ_STAT, 32'hC, 32'hC);
		wr(sec_pkg::REG_IRQ_EN, 32'h0);
		repeat (2) @(posedge i_clk);
		`CHK("irq masked", 1'h0, irq)
		wr(sec_pkg::REG_IRQ_CLR, 32'hF);
		wr(sec_pkg::REG_IRQ_EN, 32'hC);
		repeat (2) @(posedge i_clk);
		`CHK("irq cleared", 1'h0, irq)
	endtask : t_irq

	task automatic t_locked();
		other_busy <= 1'h1;
		idle();
		rchk(sec_pkg::REG_STATUS, 32'h200, 32'h200);
		do_preset(32'h55, 32'h0);
		other_busy <= 1'h0;
		idle();
		rchk(sec_pkg::REG_STATUS, 32'h200, 32'h0);
	endtask : t_locked

	task automatic t_ack();
		fault <= 1'h1;
		@(posedge i_clk);
		fault <= 1'h0;
		idle();
		rchk(sec_pkg::REG_STATUS, 32'h110, 32'h100);
		wr(sec_pkg::REG_CTRL, 32'h8);
		idle();
		rchk(sec_pkg::REG_STATUS, 32'h110, 32'h100);
		`CHK("ack request", 1'h1, ack_req)
		wr(sec_pkg::REG_CTRL, 32'hC);
		idle();
		rchk(sec_pkg::REG_STATUS, 32'h100, 32'h0);
	endtask : t_ack

	task automatic stop_test();
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		repeat (12) @(posedge i_clk);
		i_rst <= 1'h0;
		@(posedge i_clk);
		t_records();
		t_cycle();
		do_preset(RNG, 32'h08);
		do_preset(RNG - 32'h1, 32'h04);
		do_preset(32'h0, 32'h04);
		t_irq();
		t_locked();
		t_ack();
		stop_test();
	end
endmodule : tb_safe_encoder_cyclic_data

// file: hw/sec_crc48.sv
// CRC over the parameter record
`timescale 1ns/1ps
module sec_crc48 (
	input wire logic [47:0] i_data,
	output logic [31:0] o_crc
);

	logic [31:0] c;

	// Bitwise form keeps area small; record is checked on every record request
	always_comb begin
		c = sec_pkg::CRC_INIT;
		for (int i = 47; i >= 0; i--) begin
			if (c[31] ^ i_data[i]) begin
				c = {c[30:0], 1'b0} ^ sec_pkg::CRC_POLY;
			end else begin
				c = {c[30:0], 1'b0};
			end
		end
		o_crc = c;
	end

endmodule : sec_crc48

// file: hw/sec_device.sv
// Encoder submodule end of the cyclic safety data link
`timescale 1ns/1ps
module sec_device (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	sec_link_if.dev link,
	input wire logic [31:0] i_raw_pos,
	input wire logic [31:0] i_velocity,
	input wire logic i_vel_out_of_range,
	input wire logic i_safe_fault,
	input wire logic i_other_preset_busy,
	output logic [31:0] o_position,
	output logic o_preset_load,
	output logic [31:0] o_preset_value,
	output logic o_preset_busy,
	output logic o_params_ok,
	output logic [31:0] o_meas_range,
	output logic [2:0] o_vel_format,
	output logic o_direction,
	output logic o_ack_req
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		sec_pkg::sec_pre_t pre;
		logic in_valid;
		logic [79:0] in_image;
		logic rec_ack;
		logic rec_ok;
		logic params_ok;
		logic [31:0] range;
		logic [7:0] vfmt;
		logic [7:0] dir;
		logic [31:0] offset;
		logic [31:0] pos;
		logic [31:0] preset;
		logic ack_req;
		logic safe_flag;
		logic preset_ok;
		logic preset_err;
		logic preset_act;
		logic load;
	} sec_dev_st_t;

	localparam sec_dev_st_t DEV_RST = '{
		pre: sec_pkg::PS_IDLE,
		range: sec_pkg::RANGE_RST,
		vfmt: sec_pkg::VFMT_RST,
		dir: sec_pkg::DIR_RST,
		default: '0
	};

	sec_dev_st_t st_reg;
	sec_dev_st_t st_next;

	// ----------------------------------------
	// Decode of the controller image
	// ----------------------------------------
	logic [7:0] cont1;
	logic prep;
	logic req;
	logic [31:0] preset_in;
	logic [31:0] crc_calc;
	logic rec_good;
	logic [32:0] pos_sum;
	logic [31:0] pos_wrap;
	logic [7:0] stat1;
	logic [7:0] stat2;

	// Only the two preset bits are looked at; the rest and the spare byte are dropped
	assign cont1 = link.out_image[sec_pkg::OUT_CONT1_LSB +: 8];
	assign prep = cont1[sec_pkg::CT1_PREP];
	assign req = cont1[sec_pkg::CT1_REQ];
	assign preset_in = link.out_image[sec_pkg::OUT_PRESET_LSB +: 32];

	sec_crc48 u_crc (
		.i_data(link.rec_data),
		.o_crc(crc_calc)
	);

	assign rec_good = (link.rec_index == sec_pkg::PAR_INDEX) && (crc_calc == link.rec_crc);

	// ----------------------------------------
	// Position with zero-point offset, kept inside the measuring range
	// ----------------------------------------
	// Raw position is assumed already below the range; one subtraction then suffices
	assign pos_sum = {1'b0, i_raw_pos} + {1'b0, st_reg.offset};
	assign pos_wrap = (pos_sum >= {1'b0, st_reg.range}) ?
		32'(pos_sum - {1'b0, st_reg.range}) : pos_sum[31:0];

	// ----------------------------------------
	// Status bytes
	// ----------------------------------------
	always_comb begin
		stat1 = 8'h00;
		stat1[sec_pkg::ST1_VEL_ERR] = i_vel_out_of_range;
		stat1[sec_pkg::ST1_PRESET_OK] = st_reg.preset_ok;
		stat1[sec_pkg::ST1_PRESET_ERR] = st_reg.preset_err;
		stat1[sec_pkg::ST1_SAFE] = st_reg.safe_flag & st_reg.params_ok & ~st_reg.ack_req;
		stat1[sec_pkg::ST1_PRESET_ACT] = st_reg.preset_act;
		stat2 = 8'h00;
		stat2[sec_pkg::ST2_ACK_REQ] = st_reg.ack_req;
		stat2[sec_pkg::ST2_LOCKED] = i_other_preset_busy;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.in_valid = 1'b0;
		st_next.rec_ack = 1'b0;
		st_next.load = 1'b0;
		st_next.pos = pos_wrap;

		// Fault has priority so a reintegration in the same cycle does not hide it
		if (i_safe_fault) begin
			st_next.ack_req = 1'b1;
		end else if (link.reintegrate) begin
			st_next.ack_req = 1'b0;
		end

		// Parameter record
		if (link.rec_req) begin
			st_next.rec_ack = 1'b1;
			st_next.rec_ok = rec_good;
			if (rec_good) begin
				st_next.params_ok = 1'b1;
				st_next.dir = link.rec_data[sec_pkg::REC_DIR_LSB +: 8];
				st_next.range = link.rec_data[sec_pkg::REC_RANGE_LSB +: 32];
				st_next.vfmt = link.rec_data[sec_pkg::REC_VFMT_LSB +: 8];
				// A record arriving mid-preset must not bring the safe flag back early
				st_next.safe_flag = (st_reg.pre == sec_pkg::PS_IDLE);
			end
		end

		// Preset handshake
		unique case (st_reg.pre)
			sec_pkg::PS_IDLE: begin
				// A request without preparation is ignored
				if (link.cyc_req && prep && !req) begin
					st_next.pre = sec_pkg::PS_PREP;
					st_next.safe_flag = 1'b0;
				end
			end
			sec_pkg::PS_PREP: begin
				if (link.cyc_req) begin
					if (!prep) begin
						st_next.pre = sec_pkg::PS_IDLE;
						st_next.safe_flag = st_reg.params_ok;
					end else if (req && !i_other_preset_busy) begin
						if (preset_in >= st_reg.range) begin
							st_next.preset_err = 1'b1;
							st_next.pre = sec_pkg::PS_HOLD;
						end else begin
							st_next.preset = preset_in;
							st_next.preset_act = 1'b1;
							st_next.pre = sec_pkg::PS_RUN;
						end
					end
				end
			end
			sec_pkg::PS_RUN: begin
				// New offset makes the reported position equal the preset
				if (st_reg.preset >= i_raw_pos) begin
					st_next.offset = st_reg.preset - i_raw_pos;
				end else begin
					st_next.offset = st_reg.preset + st_reg.range - i_raw_pos;
				end
				st_next.load = 1'b1;
				st_next.preset_act = 1'b0;
				st_next.preset_ok = 1'b1;
				st_next.pre = sec_pkg::PS_HOLD;
			end
			sec_pkg::PS_HOLD: begin
				// Result flags stand until both preset bits are released
				if (link.cyc_req && !prep && !req) begin
					st_next.preset_ok = 1'b0;
					st_next.preset_err = 1'b0;
					st_next.safe_flag = st_reg.params_ok;
					st_next.pre = sec_pkg::PS_IDLE;
				end
			end
		endcase

		// Answer every cycle request with the current image
		if (link.cyc_req) begin
			st_next.in_valid = 1'b1;
			st_next.in_image = {stat2, stat1, st_reg.pos, i_velocity};
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= DEV_RST;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.in_valid = st_reg.in_valid;
	assign link.in_image = st_reg.in_image;
	assign link.rec_ack = st_reg.rec_ack;
	assign link.rec_ok = st_reg.rec_ok;
	assign o_position = st_reg.pos;
	assign o_preset_load = st_reg.load;
	assign o_preset_value = st_reg.preset;
	assign o_preset_busy = st_reg.preset_act;
	assign o_params_ok = st_reg.params_ok;
	assign o_meas_range = st_reg.range;
	assign o_vel_format = st_reg.vfmt[2:0];
	assign o_direction = st_reg.dir[0];
	assign o_ack_req = st_reg.ack_req;

endmodule : sec_device

// file: hw/sec_host.sv
// Safety controller end of the link with an AHB-Lite register slave
`timescale 1ns/1ps
module sec_host (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_irq,
	sec_link_if.ctl link
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [3:0] ctrl;
		logic [31:0] preset;
		logic [31:0] p_range;
		logic [7:0] p_dir;
		logic [7:0] p_vfmt;
		logic [31:0] p_crc;
		logic cyc_req;
		logic [7:0] cnt;
		logic rec_req;
		logic reint;
		logic [7:0] stat1;
		logic [7:0] stat2;
		logic [31:0] pos;
		logic [31:0] vel;
		logic rec_done;
		logic rec_ok;
		logic [3:0] irq_st;
		logic [3:0] irq_en;
		logic irq;
	} sec_host_st_t;

	localparam sec_host_st_t HOST_RST = '{
		p_range: sec_pkg::RANGE_RST,
		p_dir: sec_pkg::DIR_RST,
		p_vfmt: sec_pkg::VFMT_RST,
		default: '0
	};

	sec_host_st_t st_reg;
	sec_host_st_t st_next;
	logic sel;
	logic [3:0] ev;
	logic [3:0] clr;
	logic [7:0] new_stat1;

	function automatic logic [31:0] sec_rd(input logic [7:0] a, input sec_host_st_t s);
		logic [31:0] d;
		d = 32'h00000000;
		unique case (a)
			sec_pkg::REG_CTRL: d = {28'h0000000, s.ctrl[sec_pkg::CTRL_EN], 1'b0, s.ctrl[1:0]};
			sec_pkg::REG_PRESET: d = s.preset;
			sec_pkg::REG_PAR_RANGE: d = s.p_range;
			sec_pkg::REG_PAR_CFG: d = {16'h0000, s.p_dir, s.p_vfmt};
			sec_pkg::REG_PAR_CRC: d = s.p_crc;
			sec_pkg::REG_PAR_GO: d = {30'h00000000, s.rec_ok, s.rec_done};
			sec_pkg::REG_STATUS: d = {16'h0000, s.stat2, s.stat1};
			sec_pkg::REG_POS: d = s.pos;
			sec_pkg::REG_VEL: d = s.vel;
			sec_pkg::REG_IRQ_STAT: d = {28'h0000000, s.irq_st};
			sec_pkg::REG_IRQ_EN: d = {28'h0000000, s.irq_en};
			default: d = 32'h00000000;
		endcase
		return d;
	endfunction : sec_rd

	// ----------------------------------------
	// Bus and link logic
	// ----------------------------------------
	assign sel = i_hsel & i_hready & i_htrans[1];
	assign new_stat1 = link.in_image[sec_pkg::IN_STAT1_LSB +: 8];

	always_comb begin
		st_next = st_reg;
		st_next.cyc_req = 1'b0;
		st_next.rec_req = 1'b0;
		st_next.reint = 1'b0;
		st_next.wr_pend = 1'b0;
		clr = 4'h0;

		// Address phase; zero wait states so the read word is ready for the data phase
		if (sel) begin
			st_next.wr_pend = i_hwrite;
			st_next.wr_addr = i_haddr[7:0];
			if (!i_hwrite) begin
				st_next.hrdata = sec_rd(i_haddr[7:0], st_reg);
			end
		end

		// Data phase of a write
		if (st_reg.wr_pend) begin
			unique case (st_reg.wr_addr)
				sec_pkg::REG_CTRL: begin
					st_next.ctrl = i_hwdata[3:0];
					st_next.reint = i_hwdata[sec_pkg::CTRL_REINT];
				end
				sec_pkg::REG_PRESET: st_next.preset = i_hwdata;
				sec_pkg::REG_PAR_RANGE: st_next.p_range = i_hwdata;
				sec_pkg::REG_PAR_CFG: begin
					st_next.p_dir = i_hwdata[15:8];
					st_next.p_vfmt = i_hwdata[7:0];
				end
				sec_pkg::REG_PAR_CRC: st_next.p_crc = i_hwdata;
				sec_pkg::REG_PAR_GO: begin
					st_next.rec_req = i_hwdata[0];
					st_next.rec_done = 1'b0;
				end
				sec_pkg::REG_IRQ_EN: st_next.irq_en = i_hwdata[3:0];
				sec_pkg::REG_IRQ_CLR: clr = i_hwdata[3:0];
				default: begin
				end
			endcase
		end

		// Cyclic exchange
		if (st_reg.ctrl[sec_pkg::CTRL_EN]) begin
			if (st_reg.cnt == sec_pkg::CYC_CNT_LAST) begin
				st_next.cnt = 8'h00;
				st_next.cyc_req = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + 8'h01;
			end
		end else begin
			st_next.cnt = 8'h00;
		end

		ev = 4'h0;
		if (link.in_valid) begin
			st_next.stat2 = link.in_image[sec_pkg::IN_STAT2_LSB +: 8];
			st_next.stat1 = new_stat1;
			st_next.pos = link.in_image[sec_pkg::IN_POS_LSB +: 32];
			st_next.vel = link.in_image[sec_pkg::IN_VEL_LSB +: 32];
			ev[sec_pkg::IRQ_CYC] = 1'b1;
			ev[sec_pkg::IRQ_POK] = new_stat1[sec_pkg::ST1_PRESET_OK] &
				~st_reg.stat1[sec_pkg::ST1_PRESET_OK];
			ev[sec_pkg::IRQ_PERR] = new_stat1[sec_pkg::ST1_PRESET_ERR] &
				~st_reg.stat1[sec_pkg::ST1_PRESET_ERR];
		end
		if (link.rec_ack) begin
			st_next.rec_done = 1'b1;
			st_next.rec_ok = link.rec_ok;
			ev[sec_pkg::IRQ_REC] = 1'b1;
		end

		// Set beats clear so no event is lost
		st_next.irq_st = (st_reg.irq_st & ~clr) | ev;
		st_next.irq = |(st_next.irq_st & st_next.irq_en);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= HOST_RST;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_hrdata = st_reg.hrdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_irq = st_reg.irq;
	assign link.cyc_req = st_reg.cyc_req;
	// Spare control byte and unused control bits go out as zero
	assign link.out_image = {8'h00, 6'h00, st_reg.ctrl[1:0], st_reg.preset};
	assign link.rec_req = st_reg.rec_req;
	assign link.rec_index = sec_pkg::PAR_INDEX;
	assign link.rec_data = {st_reg.p_dir, st_reg.p_range, st_reg.p_vfmt};
	assign link.rec_crc = st_reg.p_crc;
	assign link.reintegrate = st_reg.reint;

endmodule : sec_host

// file: hw/sec_link_if.sv
// Link between safety controller and encoder submodule
`timescale 1ns/1ps
interface sec_link_if;
	logic cyc_req;
	logic [47:0] out_image;
	logic in_valid;
	logic [79:0] in_image;
	logic rec_req;
	logic [15:0] rec_index;
	logic [47:0] rec_data;
	logic [31:0] rec_crc;
	logic rec_ack;
	logic rec_ok;
	logic reintegrate;

	modport dev (
		input cyc_req, out_image, rec_req, rec_index, rec_data, rec_crc, reintegrate,
		output in_valid, in_image, rec_ack, rec_ok
	);
	modport ctl (
		output cyc_req, out_image, rec_req, rec_index, rec_data, rec_crc, reintegrate,
		input in_valid, in_image, rec_ack, rec_ok
	);
endinterface : sec_link_if

// file: hw/sec_pkg.sv
// Shared constants and types of the safe encoder cyclic data link
package sec_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int CYCLE_TIME_NS = 1000;
	localparam int CYCLE_CYCLES = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CYC_CNT_LAST = 8'(CYCLE_CYCLES - 1);

	// ----------------------------------------
	// Cyclic images, first byte on the wire in the top bits
	// ----------------------------------------
	localparam int IN_W = 80;
	localparam int OUT_W = 48;
	localparam int IN_STAT2_LSB = 72;
	localparam int IN_STAT1_LSB = 64;
	localparam int IN_POS_LSB = 32;
	localparam int IN_VEL_LSB = 0;
	localparam int OUT_CONT2_LSB = 40;
	localparam int OUT_CONT1_LSB = 32;
	localparam int OUT_PRESET_LSB = 0;

	// ----------------------------------------
	// Status and control bit positions
	// ----------------------------------------
	localparam int ST1_VEL_ERR = 0;
	localparam int ST1_PRESET_OK = 2;
	localparam int ST1_PRESET_ERR = 3;
	localparam int ST1_SAFE = 4;
	localparam int ST1_PRESET_ACT = 5;
	localparam int ST2_ACK_REQ = 0;
	localparam int ST2_LOCKED = 1;
	localparam int CT1_PREP = 0;
	localparam int CT1_REQ = 1;

	// ----------------------------------------
	// Parameter record
	// ----------------------------------------
	localparam int REC_W = 48;
	localparam int REC_DIR_LSB = 40;
	localparam int REC_RANGE_LSB = 8;
	localparam int REC_VFMT_LSB = 0;
	localparam logic [15:0] PAR_INDEX = 16'h0001;
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] RANGE_RST = 32'h20000000;
	localparam logic [7:0] VFMT_RST = 8'h01;
	localparam logic [7:0] DIR_RST = 8'h01;

	// ----------------------------------------
	// Controller register map
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PRESET = 8'h04;
	localparam logic [7:0] REG_PAR_RANGE = 8'h08;
	localparam logic [7:0] REG_PAR_CFG = 8'h0C;
	localparam logic [7:0] REG_PAR_CRC = 8'h10;
	localparam logic [7:0] REG_PAR_GO = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_POS = 8'h1C;
	localparam logic [7:0] REG_VEL = 8'h20;
	localparam logic [7:0] REG_IRQ_STAT = 8'h24;
	localparam logic [7:0] REG_IRQ_EN = 8'h28;
	localparam logic [7:0] REG_IRQ_CLR = 8'h2C;
	localparam int CTRL_PREP = 0;
	localparam int CTRL_REQ = 1;
	localparam int CTRL_REINT = 2;
	localparam int CTRL_EN = 3;
	localparam int IRQ_CYC = 0;
	localparam int IRQ_REC = 1;
	localparam int IRQ_POK = 2;
	localparam int IRQ_PERR = 3;

	typedef enum logic [1:0] {PS_IDLE, PS_PREP, PS_RUN, PS_HOLD} sec_pre_t;

endpackage : sec_pkg
